// ===== rss_pkg.sv
package rss_pkg;
    // Power-up delay, nominal
    localparam int DELAY_MS = 96;
    // Internal RC oscillator rate used to time the power-up delay
    localparam int RC_OSC_HZ = 32_000;
    localparam int DELAY_RC_TICKS = (DELAY_MS * RC_OSC_HZ) / 1000;
    // System clock rate
    localparam int REF_CLK_HZ = 25_000_000;
    // System clocks per RC oscillator tick; unused, the delay timer counts rc_tick only
    localparam int RC_DIV_CYCLES = REF_CLK_HZ / RC_OSC_HZ;
    localparam int DELAY_CNT_W = 16;
    localparam logic [1:0] PHASE_FIRST = 2'h0;
    localparam logic [1:0] PHASE_STEP = 2'h1;
    localparam logic STROBE_IDLE_ALE = 1'h0;
    localparam logic STROBE_IDLE_RD_WR = 1'h1;

    typedef enum logic [1:0] {
        RSS_POR_HOLD = 2'b00,
        RSS_DELAY_RUN = 2'b01,
        RSS_SYNC_REL = 2'b10,
        RSS_RUN = 2'b11
    } rss_state_t;
endpackage

// ===== rss_power_up_delay_timer.sv
`timescale 1ns/1ps
// Power-up delay counter; counts ticks of the dedicated RC oscillator only
module rss_delay_timer
    import rss_pkg::*;
#(
    parameter int TICKS = DELAY_RC_TICKS
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic rc_tick,
    output logic busy
);
    logic [DELAY_CNT_W-1:0] count;
    logic [DELAY_CNT_W-1:0] next_count;
    logic next_busy;

    always_comb
    begin
        next_count = count;
        next_busy = busy;
        if (start)
        begin
            next_count = DELAY_CNT_W'(TICKS);
            next_busy = 1'h1;
        end
        else if (busy && rc_tick)
        begin
            if (count <= DELAY_CNT_W'(1))
            begin
                next_count = '0;
                next_busy = 1'h0;
            end
            else
            begin
                next_count = count - DELAY_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            count <= '0;
            busy <= 1'h0;
        end
        else
        begin
            count <= next_count;
            busy <= next_busy;
        end
    end

    busy_needs_tick_a: assert property (@(posedge ref_clk) disable iff (reset)
        busy && !rc_tick && !start |=> busy) else $error("delay ended without rc tick");
endmodule

// ===== rss_reset_seq.sv
`timescale 1ns/1ps
// How it works
// - Three reset sources: power-on, master-clear pin low, watchdog timeout.
// - Power-on-only registers get a clear pulse on power-on; kept otherwise.
// - Other registers reset on power-on, master-clear, or awake watchdog.
// - Watchdog timeout while sleeping only wakes the core, no register reset.
// - Timeout and power-down status bits follow the reset cause.
// - During reset the phase sequencer is held in its first phase.
// - During reset in external modes: latch strobe low, read/write strobes high.
// - Reset held while power-on detector reports low supply.
// - Power-up delay starts at power-on rise once master clear seen high.
// - Reset held while the power-up delay runs.
// - Power-up delay is timed by its own RC oscillator ticks.
// - Master-clear reset leaves both status bits unchanged.
module rss_reset_seq
    import rss_pkg::*;
#(
    parameter int DELAY_TICKS = DELAY_RC_TICKS
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic por_ok,
    input wire logic master_clear_pin_n,
    input wire logic watchdog_timeout,
    input wire logic sleeping,
    input wire logic clrwdt_exec,
    input wire logic sleep_exec,
    input wire logic ext_exec_mode,
    input wire logic rc_tick,
    input wire logic core_ale,
    input wire logic core_oe_n,
    input wire logic core_wr_n,
    output logic core_reset,
    output logic reg_init,
    output logic por_init,
    output logic wake_up,
    output logic timeout_status_bit,
    output logic powerdown_status_bit,
    output logic [1:0] clock_phase,
    output logic address_latch_strobe,
    output logic output_enable_strobe_n,
    output logic write_strobe_n
);
    rss_state_t state;
    rss_state_t next_state;
    logic clear_seen_high;
    logic next_clear_seen_high;
    logic delay_start;
    logic delay_busy;
    logic watchdog_reset_req;
    logic any_src;
    logic next_core_reset;
    logic next_reg_init;
    logic next_por_init;
    logic next_wake_up;
    logic next_timeout;
    logic next_powerdown;
    logic [1:0] next_phase;
    logic next_ale;
    logic next_oe_n;
    logic next_wr_n;

    rss_delay_timer #(.TICKS(DELAY_TICKS)) u_delay (
        .ref_clk(ref_clk),
        .reset(reset),
        .start(delay_start),
        .rc_tick(rc_tick),
        .busy(delay_busy)
    );

    // Awake watchdog resets; asleep it only wakes the core
    assign watchdog_reset_req = watchdog_timeout && !sleeping;
    assign any_src = !por_ok || !master_clear_pin_n || watchdog_reset_req || delay_busy;

    always_comb
    begin
        next_state = state;
        next_clear_seen_high = clear_seen_high;
        delay_start = 1'h0;
        unique case (state)
            RSS_POR_HOLD:
            begin
                if (master_clear_pin_n)
                    next_clear_seen_high = 1'h1;
                // A level test suffices: this state is only left by starting the delay
                if (por_ok && (master_clear_pin_n || clear_seen_high))
                begin
                    delay_start = 1'h1;
                    next_state = RSS_DELAY_RUN;
                end
            end
            RSS_DELAY_RUN:
            begin
                if (!por_ok)
                    next_state = RSS_POR_HOLD;
                else if (!delay_busy && !delay_start)
                    next_state = RSS_SYNC_REL;
            end
            RSS_SYNC_REL:
            begin
                if (!por_ok)
                    next_state = RSS_POR_HOLD;
                else if (!any_src)
                    next_state = RSS_RUN;
            end
            RSS_RUN:
            begin
                if (!por_ok)
                    next_state = RSS_POR_HOLD;
                else if (any_src)
                    next_state = RSS_SYNC_REL;
            end
        endcase
        if (next_state == RSS_POR_HOLD && state != RSS_POR_HOLD)
            next_clear_seen_high = 1'h0;
    end

    always_comb
    begin
        next_core_reset = (next_state != RSS_RUN);
        next_por_init = (next_state == RSS_POR_HOLD);
        // A sleeping watchdog never raises a source, so any held reset here is a real one
        next_reg_init = next_core_reset;
        next_wake_up = sleeping && watchdog_timeout && state == RSS_RUN;
        next_timeout = timeout_status_bit;
        next_powerdown = powerdown_status_bit;
        if (!por_ok)
        begin
            next_timeout = 1'h1;
            next_powerdown = 1'h1;
        end
        else if (watchdog_timeout)
        begin
            next_timeout = 1'h0;
            next_powerdown = !sleeping;
        end
        else if (clrwdt_exec)
        begin
            next_timeout = 1'h1;
            next_powerdown = 1'h1;
        end
        else if (sleep_exec)
        begin
            next_timeout = 1'h1;
            next_powerdown = 1'h0;
        end
        next_phase = next_core_reset ? PHASE_FIRST : clock_phase + PHASE_STEP;
        if (next_core_reset && ext_exec_mode)
        begin
            next_ale = STROBE_IDLE_ALE;
            next_oe_n = STROBE_IDLE_RD_WR;
            next_wr_n = STROBE_IDLE_RD_WR;
        end
        else
        begin
            next_ale = core_ale;
            next_oe_n = core_oe_n;
            next_wr_n = core_wr_n;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state <= RSS_POR_HOLD;
            clear_seen_high <= 1'h0;
            core_reset <= 1'h1;
            reg_init <= 1'h1;
            por_init <= 1'h1;
            wake_up <= 1'h0;
            timeout_status_bit <= 1'h1;
            powerdown_status_bit <= 1'h1;
            clock_phase <= PHASE_FIRST;
            address_latch_strobe <= STROBE_IDLE_ALE;
            output_enable_strobe_n <= STROBE_IDLE_RD_WR;
            write_strobe_n <= STROBE_IDLE_RD_WR;
        end
        else
        begin
            state <= next_state;
            clear_seen_high <= next_clear_seen_high;
            core_reset <= next_core_reset;
            reg_init <= next_reg_init;
            por_init <= next_por_init;
            wake_up <= next_wake_up;
            timeout_status_bit <= next_timeout;
            powerdown_status_bit <= next_powerdown;
            clock_phase <= next_phase;
            address_latch_strobe <= next_ale;
            output_enable_strobe_n <= next_oe_n;
            write_strobe_n <= next_wr_n;
        end
    end

    por_holds_reset_a: assert property (@(posedge ref_clk) disable iff (reset)
        !por_ok |=> core_reset && por_init) else $error("reset not held on low supply");
    delay_holds_reset_a: assert property (@(posedge ref_clk) disable iff (reset)
        delay_busy |=> core_reset) else $error("reset released during power-up delay");
    clear_holds_reset_a: assert property (@(posedge ref_clk) disable iff (reset)
        !master_clear_pin_n |=> core_reset && reg_init) else $error("master clear ignored");
    phase_frozen_a: assert property (@(posedge ref_clk) disable iff (reset)
        core_reset |-> clock_phase == PHASE_FIRST) else $error("phase moved in reset");
    strobe_park_a: assert property (@(posedge ref_clk) disable iff (reset)
        core_reset && $past(ext_exec_mode) |-> !address_latch_strobe && output_enable_strobe_n && write_strobe_n)
        else $error("strobes not parked in reset");
    clear_keeps_status_a: assert property (@(posedge ref_clk) disable iff (reset)
        por_ok && !watchdog_timeout && !clrwdt_exec && !sleep_exec |=> $stable(timeout_status_bit)
        && $stable(powerdown_status_bit)) else $error("status bits changed");
    watchdog_status_a: assert property (@(posedge ref_clk) disable iff (reset)
        por_ok && watchdog_timeout |=> !timeout_status_bit && (powerdown_status_bit == !$past(sleeping)))
        else $error("watchdog status wrong");
    sleep_wake_a: assert property (@(posedge ref_clk) disable iff (reset)
        state == RSS_RUN && sleeping && watchdog_timeout && por_ok && master_clear_pin_n && !delay_busy
        |=> wake_up && !reg_init) else $error("sleep watchdog reset registers");
    delay_start_a: assert property (@(posedge ref_clk) disable iff (reset)
        delay_start |=> delay_busy || DELAY_TICKS == 0) else $error("delay not started");
    release_sync_a: assert property (@(posedge ref_clk) disable iff (reset)
        $fell(core_reset) |-> $past(!any_src)) else $error("release while source active");
    por_init_a: assert property (@(posedge ref_clk) disable iff (reset)
        por_init |-> reg_init) else $error("power-on init without register init");
    reg_init_a: assert property (@(posedge ref_clk) disable iff (reset)
        watchdog_reset_req |=> reg_init) else $error("awake watchdog did not reset");
endmodule

// ===== rss_supply_model.sv
`timescale 1ns/1ps
// Supply monitor, master-clear button and the free-running RC oscillator
module rss_supply_model
(
    input wire logic ref_clk,
    input wire logic supply_on,
    input wire logic button_down,
    output logic por_ok,
    output logic master_clear_pin_n,
    output logic rc_tick
);
    // Outputs stay unknown until the first falling edge; the block is still held in reset then
    logic [2:0] div = 3'h0;
    // Falling edge, so the block samples settled levels; the RC rate never stops for resets
    always @(negedge ref_clk)
    begin
        div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
        rc_tick <= (div == 3'h4);
        por_ok <= supply_on;
        master_clear_pin_n <= !button_down;
    end
endmodule

// ===== tb_reset_source_sequencer.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module tb_reset_source_sequencer;
    import rss_pkg::*;
    // Each RC tick is five system clocks in the supply model
    localparam int TICKS = 4;
    logic ref_clk, reset, supply_on, button_down, por_ok, master_clear_pin_n, rc_tick;
    logic watchdog_timeout, sleeping, clrwdt_exec, sleep_exec, ext_exec_mode;
    logic core_reset, reg_init, por_init, wake_up, timeout_status_bit, powerdown_status_bit;
    logic address_latch_strobe, output_enable_strobe_n, write_strobe_n;
    logic [1:0] clock_phase;
    logic [1:0] p;
    int failures = 0;
    int n_compared = 0;
    int n;
    rss_supply_model partner (.ref_clk(ref_clk), .supply_on(supply_on), .button_down(button_down),
        .por_ok(por_ok), .master_clear_pin_n(master_clear_pin_n), .rc_tick(rc_tick));
    rss_reset_seq #(.DELAY_TICKS(TICKS)) dut (.ref_clk(ref_clk), .reset(reset), .por_ok(por_ok),
        .master_clear_pin_n(master_clear_pin_n), .watchdog_timeout(watchdog_timeout),
        .sleeping(sleeping), .clrwdt_exec(clrwdt_exec), .sleep_exec(sleep_exec),
        .ext_exec_mode(ext_exec_mode), .rc_tick(rc_tick), .core_ale(1'h1), .core_oe_n(1'h0),
        .core_wr_n(1'h0), .core_reset(core_reset), .reg_init(reg_init), .por_init(por_init),
        .wake_up(wake_up), .timeout_status_bit(timeout_status_bit),
        .powerdown_status_bit(powerdown_status_bit), .clock_phase(clock_phase),
        .address_latch_strobe(address_latch_strobe),
        .output_enable_strobe_n(output_enable_strobe_n), .write_strobe_n(write_strobe_n));
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic print_verdict;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wait_core(input logic v);
        n = 0;
        while (core_reset !== v && n < 200)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (core_reset !== v)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, core_reset, v);
            print_verdict();
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        @(negedge ref_clk);
        s = 1'h0;
        repeat (3) @(negedge ref_clk);
    endtask
    task automatic scen_power_up;
        repeat (20) @(negedge ref_clk);
        `CHK(core_reset, 1'h1)
        `CHK(clock_phase, PHASE_FIRST)
        `CHK({address_latch_strobe, output_enable_strobe_n, write_strobe_n}, 3'h3)
        `CHK(por_init, 1'h1)
        supply_on = 1'h1;
        wait_core(1'h0);
        // Release needs the whole delay plus the synchronising state
        `CHK(n >= TICKS * 5, 1'h1)
        `CHK(n <= TICKS * 5 + 12, 1'h1)
        `CHK({timeout_status_bit, powerdown_status_bit}, 2'h3)
        `CHK(reg_init, 1'h0)
        @(negedge ref_clk);
        p = clock_phase;
        @(negedge ref_clk);
        `CHK(clock_phase, p + PHASE_STEP)
        `CHK({address_latch_strobe, output_enable_strobe_n, write_strobe_n}, 3'h4)
    endtask
    task automatic scen_watchdog_awake;
        // The watchdog reset stands for one cycle only, so it is judged while it stands
        ext_exec_mode = 1'h0;
        watchdog_timeout = 1'h1;
        @(negedge ref_clk);
        watchdog_timeout = 1'h0;
        `CHK(core_reset, 1'h1)
        `CHK(reg_init, 1'h1)
        `CHK(por_init, 1'h0)
        `CHK(clock_phase, PHASE_FIRST)
        // Without external execution the core strobes pass through even in reset
        `CHK({address_latch_strobe, output_enable_strobe_n, write_strobe_n}, 3'h4)
        ext_exec_mode = 1'h1;
        wait_core(1'h0);
        `CHK(n, 1)
        `CHK({timeout_status_bit, powerdown_status_bit}, 2'h1)
    endtask
    task automatic scen_watchdog_asleep;
        int seen;
        int bad;
        seen = 0;
        bad = 0;
        sleeping = 1'h1;
        pulse(sleep_exec);
        `CHK({timeout_status_bit, powerdown_status_bit}, 2'h2)
        watchdog_timeout = 1'h1;
        @(negedge ref_clk);
        watchdog_timeout = 1'h0;
        repeat (4)
        begin
            if (wake_up === 1'h1)
                seen++;
            if (reg_init !== 1'h0 || core_reset !== 1'h0)
                bad++;
            @(negedge ref_clk);
        end
        sleeping = 1'h0;
        `CHK(seen, 1)
        `CHK(bad, 0)
        `CHK({timeout_status_bit, powerdown_status_bit}, 2'h0)
    endtask
    task automatic scen_clear_sleep;
        pulse(clrwdt_exec);
        `CHK({timeout_status_bit, powerdown_status_bit}, 2'h3)
        sleeping = 1'h1;
        pulse(sleep_exec);
        button_down = 1'h1;
        repeat (10) @(negedge ref_clk);
        `CHK(core_reset, 1'h1)
        `CHK(reg_init, 1'h1)
        `CHK(por_init, 1'h0)
        `CHK({timeout_status_bit, powerdown_status_bit}, 2'h2)
        sleeping = 1'h0;
        repeat (10) @(negedge ref_clk);
        // Still held: the pin is the one source left active
        `CHK(core_reset, 1'h1)
        button_down = 1'h0;
        wait_core(1'h0);
        `CHK(n <= 4, 1'h1)
        `CHK({timeout_status_bit, powerdown_status_bit}, 2'h2)
    endtask
    initial
    begin
        reset = 1'h1;
        supply_on = 1'h0;
        button_down = 1'h0;
        watchdog_timeout = 1'h0;
        sleeping = 1'h0;
        clrwdt_exec = 1'h0;
        sleep_exec = 1'h0;
        ext_exec_mode = 1'h1;
        repeat (2) @(negedge ref_clk);
        reset = 1'h0;
        scen_power_up();
        scen_watchdog_awake();
        scen_watchdog_asleep();
        scen_clear_sleep();
        print_verdict();
    end
endmodule
